// File: logic/refstatus_eeprom_ctrl_params.svh
// Function
// - Valid flag: bit 7 second, bit 3 first; unfaulted and validated.
// - Fault flag per input: bit 6 second, bit 2 first; input not usable.
// - Too-fast flag: bit 5 second, bit 1 first; above upper limit.
// - Too-slow flag: bit 4 second, bit 0 first; below lower limit.
// - Fast and slow both set means the input clock is missing.
// - Status becomes readable only after writing 0x01 to offset 0x0005.
// - Four read-only bytes, low byte first, show the 30-bit tuning word.
// - Phase lock level 12 bits at 0x0D11 and 0x0D12[3:0].
// - Frequency lock level 12 bits at 0x0D13 and 0x0D14[3:0].
// - Write protect bit resets to 0, protected; 1 permits writes.
// - Write protect bit acts at once, no transfer strobe needed.
// - 4-bit condition, reset zero, live; non-zero sets condition.
// - Save bit 0 at 0x0E02 starts upload at once if not busy, then self-clears.
// - Load bit 1 at 0x0E03 starts download at once if not busy, then self-clears.
// - Memory fault flag on failed transfer, completion flag on success.
`ifndef REFSTATUS_EEPROM_CTRL_PARAMS_SVH
`define REFSTATUS_EEPROM_CTRL_PARAMS_SVH
`define ADDR_EVENT_STATUS 12'h0D00
`define ADDR_TRANSFER 12'h0005
`define TRANSFER_VALUE 8'h01
`define ADDR_REF_STATUS 12'h0D0B
`define ADDR_RSVD_0D0C 12'h0D0C
`define ADDR_TW0 12'h0D0D
`define ADDR_TW1 12'h0D0E
`define ADDR_TW2 12'h0D0F
`define ADDR_TW3 12'h0D10
`define ADDR_PH_LO 12'h0D11
`define ADDR_PH_HI 12'h0D12
`define ADDR_FR_LO 12'h0D13
`define ADDR_FR_HI 12'h0D14
`define ADDR_PROTECT 12'h0E00
`define ADDR_COND 12'h0E01
`define ADDR_SAVE 12'h0E02
`define ADDR_LOAD 12'h0E03
`define BIT_B_VALID 7
`define BIT_B_FAULT 6
`define BIT_B_FAST 5
`define BIT_B_SLOW 4
`define BIT_A_VALID 3
`define BIT_A_FAULT 2
`define BIT_A_FAST 1
`define BIT_A_SLOW 0
`define BIT_PROTECT 0
`define BIT_SAVE 0
`define BIT_LOAD 1
`define BIT_EV_BUSY 1
`define BIT_EV_COMPLETE 2
`define BIT_EV_FAULT 3
`define PROTECT_RESET 1'b0
`define COND_RESET 4'h0
`define BYTE_ZERO 8'h00
`endif

// File: logic/refstatus_eeprom_ctrl_pkg.sv
`default_nettype none
package refstatus_eeprom_ctrl_pkg;
	// Memory transfer sequencing, Gray coded along idle-run-done
	typedef enum logic [1:0] {
		MEM_IDLE = 2'b00,
		MEM_RUN = 2'b01,
		MEM_DONE = 2'b11
	} mem_state_type;
endpackage : refstatus_eeprom_ctrl_pkg
`default_nettype wire

// File: logic/refstatus_eeprom_ctrl_regs.sv
`include "refstatus_eeprom_ctrl_params.svh"
`default_nettype none
module refstatus_eeprom_ctrl_regs
	import refstatus_eeprom_ctrl_pkg::*;
#(
	parameter int TW_WIDTH = 30,
	parameter int LEVEL_WIDTH = 12
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic first_ref_fault,
	input wire logic first_ref_validated,
	input wire logic first_ref_fast,
	input wire logic first_ref_slow,
	input wire logic second_ref_fault,
	input wire logic second_ref_validated,
	input wire logic second_ref_fast,
	input wire logic second_ref_slow,
	input wire logic [TW_WIDTH-1:0] tuning_word,
	input wire logic [LEVEL_WIDTH-1:0] phase_level,
	input wire logic [LEVEL_WIDTH-1:0] freq_level,
	output logic mem_write_enable,
	output logic [3:0] download_condition,
	output logic condition_active,
	output logic save_start,
	output logic load_start,
	input wire logic mem_done,
	input wire logic mem_error,
	output logic mem_busy,
	output logic mem_fault_event,
	output logic mem_complete_event
);

	// ************************************************************
	// Snapshot of monitor status, taken on the transfer strobe
	// ************************************************************
	logic [7:0] ref_status_r, ref_status_nxt;
	logic [TW_WIDTH-1:0] tw_r, tw_nxt;
	logic [LEVEL_WIDTH-1:0] ph_r, ph_nxt;
	logic [LEVEL_WIDTH-1:0] fr_r, fr_nxt;
	logic transfer;
	logic wr_protect;
	logic wr_cond;
	logic wr_save;
	logic wr_load;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
		hit = (a == b);
	endfunction : hit

	// Byte lane of a snapshot word; lanes past the word's width read zero
	function automatic logic [7:0] lane(
		input logic [31:0] word,
		input logic [1:0] idx
	);
		lane = word[8*idx +: 8];
	endfunction : lane

	// Only the exact transfer value counts, so a stray write to the
	// strobe address cannot refresh the status view
	assign transfer = wr && hit(addr, `ADDR_TRANSFER)
		&& (wdata == `TRANSFER_VALUE);
	assign wr_protect = wr && hit(addr, `ADDR_PROTECT);
	assign wr_cond = wr && hit(addr, `ADDR_COND);
	assign wr_save = wr && hit(addr, `ADDR_SAVE);
	assign wr_load = wr && hit(addr, `ADDR_LOAD);

	always_comb begin
		ref_status_nxt = ref_status_r;
		tw_nxt = tw_r;
		ph_nxt = ph_r;
		fr_nxt = fr_r;
		if (transfer) begin
			ref_status_nxt[`BIT_B_VALID] = second_ref_validated
				&& !second_ref_fault;
			ref_status_nxt[`BIT_B_FAULT] = second_ref_fault;
			ref_status_nxt[`BIT_B_FAST] = second_ref_fast;
			ref_status_nxt[`BIT_B_SLOW] = second_ref_slow;
			ref_status_nxt[`BIT_A_VALID] = first_ref_validated
				&& !first_ref_fault;
			ref_status_nxt[`BIT_A_FAULT] = first_ref_fault;
			ref_status_nxt[`BIT_A_FAST] = first_ref_fast;
			ref_status_nxt[`BIT_A_SLOW] = first_ref_slow;
			tw_nxt = tuning_word;
			ph_nxt = phase_level;
			fr_nxt = freq_level;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_status_r <= `BYTE_ZERO;
			tw_r <= '0;
			ph_r <= '0;
			fr_r <= '0;
		end else begin
			ref_status_r <= ref_status_nxt;
			tw_r <= tw_nxt;
			ph_r <= ph_nxt;
			fr_r <= fr_nxt;
		end
	end

	// ************************************************************
	// Live control: protect, condition, save and load commands
	// ************************************************************
	logic protect_r, protect_nxt;
	logic [3:0] cond_r, cond_nxt;
	logic save_r, save_nxt;
	logic load_r, load_nxt;
	logic save_cmd, load_cmd;

	// A new command is ignored while one is running; software must wait
	assign save_cmd = wr_save && wdata[`BIT_SAVE]
		&& !mem_busy;
	assign load_cmd = wr_load && wdata[`BIT_LOAD]
		&& !mem_busy;

	always_comb begin
		protect_nxt = protect_r;
		cond_nxt = cond_r;
		if (wr_protect) begin
			protect_nxt = wdata[`BIT_PROTECT];
		end
		if (wr_cond) begin
			cond_nxt = wdata[3:0];
		end
		// Command bits self-clear after one cycle
		save_nxt = save_cmd;
		load_nxt = load_cmd;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			protect_r <= `PROTECT_RESET;
			cond_r <= `COND_RESET;
			save_r <= 1'b0;
			load_r <= 1'b0;
		end else begin
			protect_r <= protect_nxt;
			cond_r <= cond_nxt;
			save_r <= save_nxt;
			load_r <= load_nxt;
		end
	end

	assign mem_write_enable = protect_r;
	assign download_condition = cond_r;
	assign condition_active = (cond_r != 4'h0);
	assign save_start = save_r;
	assign load_start = load_r;

	// ************************************************************
	// Transfer sequencing: busy, completion and fault events
	// ************************************************************
	mem_state_type state_r, state_nxt;
	logic fault_r, fault_nxt;
	logic complete_r, complete_nxt;

	always_comb begin
		state_nxt = state_r;
		fault_nxt = 1'b0;
		complete_nxt = 1'b0;
		case (state_r)
			MEM_IDLE: begin
				if (save_cmd || load_cmd) begin
					state_nxt = MEM_RUN;
				end
			end
			MEM_RUN: begin
				if (mem_done) begin
					state_nxt = MEM_DONE;
					fault_nxt = mem_error;
					complete_nxt = !mem_error;
				end
			end
			MEM_DONE: begin
				// A command in the event cycle is accepted, so busy must
				// cover it like any other start
				if (save_cmd || load_cmd) begin
					state_nxt = MEM_RUN;
				end else begin
					state_nxt = MEM_IDLE;
				end
			end
			default: begin
				state_nxt = MEM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= MEM_IDLE;
			fault_r <= 1'b0;
			complete_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fault_r <= fault_nxt;
			complete_r <= complete_nxt;
		end
	end

	assign mem_busy = (state_r == MEM_RUN);
	assign mem_fault_event = fault_r;
	assign mem_complete_event = complete_r;

	// ************************************************************
	// Read path, data one cycle after the read strobe
	// ************************************************************
	logic [7:0] rdata_r, rdata_nxt;

	always_comb begin
		rdata_nxt = `BYTE_ZERO;
		if (rd) begin
			case (addr)
				`ADDR_EVENT_STATUS: begin
					rdata_nxt[`BIT_EV_BUSY] = mem_busy;
					rdata_nxt[`BIT_EV_COMPLETE] = complete_r;
					rdata_nxt[`BIT_EV_FAULT] = fault_r;
				end
				`ADDR_REF_STATUS: rdata_nxt = ref_status_r;
				`ADDR_TW0: rdata_nxt = lane(32'(tw_r), 2'h0);
				`ADDR_TW1: rdata_nxt = lane(32'(tw_r), 2'h1);
				`ADDR_TW2: rdata_nxt = lane(32'(tw_r), 2'h2);
				`ADDR_TW3: rdata_nxt = lane(32'(tw_r), 2'h3);
				`ADDR_PH_LO: rdata_nxt = lane(32'(ph_r), 2'h0);
				`ADDR_PH_HI: rdata_nxt = lane(32'(ph_r), 2'h1);
				`ADDR_FR_LO: rdata_nxt = lane(32'(fr_r), 2'h0);
				`ADDR_FR_HI: rdata_nxt = lane(32'(fr_r), 2'h1);
				`ADDR_PROTECT: rdata_nxt[`BIT_PROTECT] = protect_r;
				`ADDR_COND: rdata_nxt[3:0] = cond_r;
				`ADDR_SAVE: rdata_nxt[`BIT_SAVE] = save_r;
				`ADDR_LOAD: rdata_nxt[`BIT_LOAD] = load_r;
				default: rdata_nxt = `BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= `BYTE_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

endmodule : refstatus_eeprom_ctrl_regs
`default_nettype wire

// File: tb/refstatus_regs_monitor.sv
`default_nettype none
module refstatus_regs_monitor (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic mem_write_enable,
	input wire logic [3:0] download_condition,
	input wire logic condition_active,
	input wire logic save_start,
	input wire logic load_start,
	input wire logic mem_done,
	input wire logic mem_error,
	input wire logic mem_busy,
	input wire logic mem_fault_event,
	input wire logic mem_complete_event
);
	// ****************
	// Port relations
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	save_go_a: assert property (
		wr && addr == 12'h0E02 && wdata[0] && !mem_busy
		|=> save_start && mem_busy) else $error("save did not start");
	load_go_a: assert property (
		wr && addr == 12'h0E03 && wdata[1] && !mem_busy
		|=> load_start && mem_busy) else $error("load did not start");
	busy_hold_a: assert property (mem_busy && !mem_done |=> mem_busy)
		else $error("busy dropped early");
	done_event_a: assert property (mem_busy && mem_done |=> !mem_busy &&
		mem_fault_event == $past(mem_error) &&
		mem_complete_event == !$past(mem_error)) else $error("bad end event");
	protect_live_a: assert property (wr && addr == 12'h0E00
		|=> mem_write_enable == $past(wdata[0])) else $error("protect not live");
	cond_live_a: assert property (wr && addr == 12'h0E01
		|=> download_condition == $past(wdata[3:0])) else $error("cond not live");
	cond_flag_a: assert property (
		condition_active == |download_condition)
		else $error("condition flag wrong");
	rsvd_zero_a: assert property (
		rd && addr == 12'h0D0C |=> rdata == 8'h00)
		else $error("reserved read nonzero");
endmodule : refstatus_regs_monitor
bind refstatus_eeprom_ctrl_regs refstatus_regs_monitor mon (.*);
`default_nettype wire

// File: tb/refstatus_eeprom_ctrl_regs_tb_top.sv
`default_nettype none
module refstatus_eeprom_ctrl_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
	logic mem_done = 1'b0, mem_error = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00, refs = 8'h00, rdata;
	logic [29:0] tuning_word = 30'h3A5C_9617;
	logic [11:0] phase_level = 12'hABC, freq_level = 12'h5E7;
	logic [3:0] download_condition;
	logic mem_write_enable, condition_active, save_start, load_start;
	logic mem_busy, mem_fault_event, mem_complete_event;
	logic second_ref_validated, second_ref_fault, second_ref_fast;
	logic second_ref_slow, first_ref_validated, first_ref_fault;
	logic first_ref_fast, first_ref_slow;
	int fails = 0, checks_done = 0;
	logic [7:0] pat [4] = '{8'hFF, 8'h88, 8'h33, 8'h44};
	logic [31:0] snap;
	logic [7:0] want;
	assign {second_ref_validated, second_ref_fault, second_ref_fast,
		second_ref_slow, first_ref_validated, first_ref_fault,
		first_ref_fast, first_ref_slow} = refs;
	refstatus_eeprom_ctrl_regs dut (.*);
	initial forever #10 clk = ~clk;
	// ****************
	// Bus tasks
	// ****************
	task automatic chk(input logic [7:0] seen, exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] d;
		rreg(a, d);
		chk(d, e, $sformatf("read %h", a));
	endtask : rchk
	// Software polls busy before its next write; a stuck busy ends the run
	task automatic wait_idle();
		logic [7:0] v;
		v = 8'hFF;
		for (int n = 0; n < 16 && v[1] !== 1'b0; n++) begin
			rreg(12'h0D00, v);
		end
		if (v[1] !== 1'b0) begin
			fails++;
			summarize();
		end
	endtask : wait_idle
	task automatic cmd(input logic [11:0] a, input logic [7:0] d, input logic e);
		wreg(a, d);
		#1 chk({load_start, save_start}, {a[0], ~a[0]}, "start");
		chk(mem_busy, 8'h01, "busy");
		rchk(12'h0D00, 8'h02);
		rchk(a, 8'h00);
		@(posedge clk);
		mem_done <= 1'b1;
		mem_error <= e;
		@(posedge clk);
		mem_done <= 1'b0;
		#1 chk({mem_busy, mem_fault_event, mem_complete_event}, {e, ~e},
			"end");
		wait_idle();
	endtask : cmd
	task automatic summarize();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	initial begin
		#1000000;
		fails++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rchk(12'h0E00, 8'h00);
		rchk(12'h0E01, 8'h00);
		refs <= 8'hFF;
		wreg(12'h0005, 8'h02);
		rchk(12'h0D0B, 8'h00);
		foreach (pat[i]) begin
			refs <= pat[i];
			wreg(12'h0005, 8'h01);
			@(posedge clk);
			refs <= ~pat[i];
			want = pat[i] & ~{pat[i][6], 3'h0, pat[i][2], 3'h0};
			rchk(12'h0D0B, want);
		end
		// Inputs move after the snapshot; reads must keep the old values
		snap = {2'b00, tuning_word};
		tuning_word <= ~tuning_word;
		phase_level <= 12'h000;
		for (int i = 0; i < 4; i++) begin
			rchk(12'h0D0D + 12'(i), snap[8*i +: 8]);
		end
		rchk(12'h0D11, 8'hBC);
		rchk(12'h0D12, 8'h0A);
		rchk(12'h0D13, 8'hE7);
		rchk(12'h0D14, 8'h05);
		wreg(12'h0D0C, 8'hFF);
		wreg(12'h0D0B, 8'h00);
		rchk(12'h0D0C, 8'h00);
		rchk(12'h0ABC, 8'h00);
		rchk(12'h0D0B, 8'h44);
		wreg(12'h0E00, 8'hFF);
		#1 chk(mem_write_enable, 8'h01, "protect");
		rchk(12'h0E00, 8'h01);
		wreg(12'h0E01, 8'hF9);
		#1 chk({download_condition, 3'h0, condition_active}, 8'h91,
			"cond");
		rchk(12'h0E01, 8'h09);
		wreg(12'h0E01, 8'h00);
		#1 chk(condition_active, 8'h00, "cond off");
		wreg(12'h0E03, 8'h01);
		#1 chk({load_start, mem_busy}, 8'h00, "no load");
		cmd(12'h0E02, 8'h01, 1'b0);
		cmd(12'h0E03, 8'h02, 1'b1);
		// Reset cuts a running save; the retry must start clean
		wreg(12'h0E02, 8'h01);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1 chk({mem_busy, mem_write_enable, save_start}, 8'h00,
			"reset");
		cmd(12'h0E02, 8'h01, 1'b0);
		summarize();
	end
endmodule : refstatus_eeprom_ctrl_regs_tb_top
`default_nettype wire
